// >>> logic/audio_routing_map.vh
// register offsets, field positions and reset values of the routing control register
`ifndef AUDIO_ROUTING_MAP_VH
`define AUDIO_ROUTING_MAP_VH
`define ADDR_W 8
`define DATA_W 16
`define ROUTE_PAGE 2'h2
`define ROUTE_OFFSET 8'h21
`define B_FIRST_LSK 15
`define B_SIDETONE_LSK 14
`define B_BUZZER_LSK 13
`define B_KEYCLICK_LSK 12
`define B_CELLIN_LSK 11
`define B_MIC_CPO 10
`define B_FIRST_CPO 9
`define B_SECOND_CPO 8
`define B_LSK_MUTE 7
`define B_CPO_MUTE 6
`define B_LSK_SCP_OFF 5
`define B_VIRTUAL_GROUND_DRIVER_SCP_OFF 4
`define B_HS_COUPLING 3
`define ROUTE_WR_MASK 16'hfff8
`define ROUTE_RESET 16'h00e0
`define FIRST_SEL_W 6
`define SECOND_SEL_W 6
`endif

// >>> logic/audio_output_routing_control.v
// routing, mute and protection control register for the loudspeaker and cell output
`default_nettype none
`include "audio_routing_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE_01 - first-path-to-loudspeaker bit copies first speaker path sources to the loudspeaker
// RULE_02 - software sets that bit only with speaker drivers powered down
// RULE_03 - sidetone to loudspeaker bit, reset zero
// RULE_04 - buzzer gain output to loudspeaker bit, reset zero
// RULE_05 - keyclick to loudspeaker bit, reset zero
// RULE_06 - cell input to loudspeaker bit, reset zero
// RULE_07 - selected microphone to cell output bit, reset zero
// RULE_08 - first path sources except cell input also reach cell output
// RULE_09 - single-ended only: second path sources also reach cell output
// RULE_10 - software ignores second-path-to-cell bit while first path goes to loudspeaker
// RULE_11 - loudspeaker mute, resets to muted
// RULE_12 - cell output mute, resets to muted
// RULE_13 - loudspeaker short protection off bit, resets to one
// RULE_14 - virtual ground short protection off bit, resets zero
// RULE_15 - headset coupling select: zero cap-less, one capacitor-coupled
// RULE_16 - low three bits reserved, read as zero, writes ignored
// RULE_17 - register sits at offset 0x21 of control page 2
// RULE_18 - differential select chooses single-ended or differential speaker drive
// RULE_19 - reset loads field defaults; writes touch writable bits; reads show all
module audio_output_routing_control (
    // clock and reset
    input wire clock,
    input wire rst,
    // register port
    input wire [1:0] page,
    input wire [`ADDR_W-1:0] addr,
    input wire [`DATA_W-1:0] wdata,
    input wire wr,
    input wire rd,
    output reg [`DATA_W-1:0] rdata,
    // companion register fields and mode
    input wire differential_output_select,
    input wire [`FIRST_SEL_W-1:0] first_path_select,
    input wire [`SECOND_SEL_W-1:0] second_path_select,
    // analog steering outputs
    output reg sidetone_to_loudspeaker,
    output reg buzzer_to_loudspeaker,
    output reg keyclick_to_loudspeaker,
    output reg cell_input_to_loudspeaker,
    output reg [`FIRST_SEL_W-1:0] first_path_to_loudspeaker,
    output reg microphone_to_cell_output,
    output reg [`FIRST_SEL_W-1:0] first_path_to_cell_output,
    output reg [`SECOND_SEL_W-1:0] second_path_to_cell_output,
    output reg loudspeaker_mute,
    output reg cell_output_mute,
    output reg loudspeaker_short_protect_off,
    output reg virtual_ground_short_protect_off,
    output reg headset_coupling_select,
    output reg first_speaker_differential
);

    ////////////////////////////////////////////////////////////////////////////
    // named constants of the register word
    localparam [`DATA_W-1:0] RESET_WORD = `ROUTE_RESET;
    localparam [`DATA_W-1:0] WRITE_MASK = `ROUTE_WR_MASK;
    localparam [`DATA_W-1:0] READ_IDLE = {`DATA_W{1'b0}};
    localparam [`FIRST_SEL_W-1:0] FIRST_NONE = {`FIRST_SEL_W{1'b0}};
    localparam [`SECOND_SEL_W-1:0] SECOND_NONE = {`SECOND_SEL_W{1'b0}};

    // stored register word and its next value
    reg [`DATA_W-1:0] ctrl_q;
    wire [`DATA_W-1:0] ctrl_d;

    // bus decode
    wire hit;
    wire write_hit;
    wire read_hit;

    // single-bit fields of the stored word
    wire first_lsk_en;
    wire sidetone_lsk_en;
    wire buzzer_lsk_en;
    wire keyclick_lsk_en;
    wire cellin_lsk_en;
    wire mic_cpo_en;
    wire first_cpo_en;
    wire second_cpo_en;
    wire lsk_mute_bit;
    wire cpo_mute_bit;
    wire lsk_scp_off_bit;
    wire virtual_ground_driver_scp_off_bit;
    wire hs_coupling_bit;

    // next values of the multi-bit steering outputs
    wire [`FIRST_SEL_W-1:0] first_no_cell;
    wire [`FIRST_SEL_W-1:0] first_lsk_d;
    wire [`FIRST_SEL_W-1:0] first_cpo_d;
    wire second_cpo_allowed;
    wire [`SECOND_SEL_W-1:0] second_cpo_d;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: only the routing page and offset answer
    assign hit = (page == `ROUTE_PAGE) && (addr == `ROUTE_OFFSET); // [RULE_17]
    assign write_hit = wr && hit;
    assign read_hit = rd && hit;

    // reserved low bits are never stored, so they always read back as zero
    assign ctrl_d = wdata & WRITE_MASK; // [RULE_16] [RULE_19]

    ////////////////////////////////////////////////////////////////////////////
    // register word: reset value, then whatever a hit write carries
    always @(posedge clock) begin
        if (rst) begin
            ctrl_q <= RESET_WORD; // [RULE_11] [RULE_12] [RULE_13] [RULE_19]
        end else if (write_hit) begin
            ctrl_q <= ctrl_d;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always @(posedge clock) begin
        if (rst) begin
            rdata <= READ_IDLE;
        end else if (read_hit) begin
            rdata <= ctrl_q; // [RULE_19]
        end else begin
            rdata <= READ_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // loudspeaker source fields
    assign first_lsk_en = ctrl_q[`B_FIRST_LSK];
    assign sidetone_lsk_en = ctrl_q[`B_SIDETONE_LSK];
    assign buzzer_lsk_en = ctrl_q[`B_BUZZER_LSK];
    assign keyclick_lsk_en = ctrl_q[`B_KEYCLICK_LSK];
    assign cellin_lsk_en = ctrl_q[`B_CELLIN_LSK];

    // cell output source fields
    assign mic_cpo_en = ctrl_q[`B_MIC_CPO];
    assign first_cpo_en = ctrl_q[`B_FIRST_CPO];
    assign second_cpo_en = ctrl_q[`B_SECOND_CPO];

    // mute fields
    assign lsk_mute_bit = ctrl_q[`B_LSK_MUTE];
    assign cpo_mute_bit = ctrl_q[`B_CPO_MUTE];

    // protection and headset fields
    assign lsk_scp_off_bit = ctrl_q[`B_LSK_SCP_OFF];
    assign virtual_ground_driver_scp_off_bit = ctrl_q[`B_VIRTUAL_GROUND_DRIVER_SCP_OFF];
    assign hs_coupling_bit = ctrl_q[`B_HS_COUPLING];

    ////////////////////////////////////////////////////////////////////////////
    // lowest select bit is the cell input source, dropped for the cell output
    assign first_no_cell = {first_path_select[`FIRST_SEL_W-1:1], 1'b0}; // [RULE_08]
    // first path copy to the loudspeaker; software keeps the drivers down meanwhile
    assign first_lsk_d = first_lsk_en ? first_path_select : FIRST_NONE; // [RULE_01]
    // first path copy to the cell output, valid with the drivers powered down too
    assign first_cpo_d = first_cpo_en ? first_no_cell : FIRST_NONE; // [RULE_08]
    // second path copy only in single-ended mode
    assign second_cpo_allowed = second_cpo_en && !differential_output_select; // [RULE_09]
    assign second_cpo_d = second_cpo_allowed ? second_path_select : SECOND_NONE; // [RULE_09]

    ////////////////////////////////////////////////////////////////////////////
    // loudspeaker pair steering outputs

    // sidetone steering to the loudspeaker pair
    always @(posedge clock) begin
        if (rst) begin
            sidetone_to_loudspeaker <= RESET_WORD[`B_SIDETONE_LSK];
        end else begin
            sidetone_to_loudspeaker <= sidetone_lsk_en; // [RULE_03]
        end
    end

    // buzzer gain output steering to the loudspeaker pair
    always @(posedge clock) begin
        if (rst) begin
            buzzer_to_loudspeaker <= RESET_WORD[`B_BUZZER_LSK];
        end else begin
            buzzer_to_loudspeaker <= buzzer_lsk_en; // [RULE_04]
        end
    end

    // keyclick steering to the loudspeaker pair
    always @(posedge clock) begin
        if (rst) begin
            keyclick_to_loudspeaker <= RESET_WORD[`B_KEYCLICK_LSK];
        end else begin
            keyclick_to_loudspeaker <= keyclick_lsk_en; // [RULE_05]
        end
    end

    // cell input steering to the loudspeaker pair
    always @(posedge clock) begin
        if (rst) begin
            cell_input_to_loudspeaker <= RESET_WORD[`B_CELLIN_LSK];
        end else begin
            cell_input_to_loudspeaker <= cellin_lsk_en; // [RULE_06]
        end
    end

    // first speaker path sources copied to the loudspeaker pair
    always @(posedge clock) begin
        if (rst) begin
            first_path_to_loudspeaker <= FIRST_NONE;
        end else begin
            first_path_to_loudspeaker <= first_lsk_d; // [RULE_01]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cell output steering outputs

    // selected microphone steering to the cell output
    always @(posedge clock) begin
        if (rst) begin
            microphone_to_cell_output <= RESET_WORD[`B_MIC_CPO];
        end else begin
            microphone_to_cell_output <= mic_cpo_en; // [RULE_07]
        end
    end

    // first speaker path sources, cell input excluded, to the cell output
    always @(posedge clock) begin
        if (rst) begin
            first_path_to_cell_output <= FIRST_NONE;
        end else begin
            first_path_to_cell_output <= first_cpo_d; // [RULE_08]
        end
    end

    // second speaker path sources to the cell output
    always @(posedge clock) begin
        if (rst) begin
            second_path_to_cell_output <= SECOND_NONE;
        end else begin
            second_path_to_cell_output <= second_cpo_d; // [RULE_09]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mute outputs

    // loudspeaker mute, muted out of reset
    always @(posedge clock) begin
        if (rst) begin
            loudspeaker_mute <= RESET_WORD[`B_LSK_MUTE]; // [RULE_11]
        end else begin
            loudspeaker_mute <= lsk_mute_bit; // [RULE_11]
        end
    end

    // cell output mute, muted out of reset
    always @(posedge clock) begin
        if (rst) begin
            cell_output_mute <= RESET_WORD[`B_CPO_MUTE]; // [RULE_12]
        end else begin
            cell_output_mute <= cpo_mute_bit; // [RULE_12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // protection, headset and mode outputs

    // loudspeaker short protection disable, disabled out of reset
    always @(posedge clock) begin
        if (rst) begin
            loudspeaker_short_protect_off <= RESET_WORD[`B_LSK_SCP_OFF]; // [RULE_13]
        end else begin
            loudspeaker_short_protect_off <= lsk_scp_off_bit; // [RULE_13]
        end
    end

    // virtual ground short protection disable
    always @(posedge clock) begin
        if (rst) begin
            virtual_ground_short_protect_off <= RESET_WORD[`B_VIRTUAL_GROUND_DRIVER_SCP_OFF];
        end else begin
            virtual_ground_short_protect_off <= virtual_ground_driver_scp_off_bit; // [RULE_14]
        end
    end

    // headset coupling: cap-less when low
    always @(posedge clock) begin
        if (rst) begin
            headset_coupling_select <= RESET_WORD[`B_HS_COUPLING];
        end else begin
            headset_coupling_select <= hs_coupling_bit; // [RULE_15]
        end
    end

    // single-ended or differential speaker drive, following the companion bit
    always @(posedge clock) begin
        if (rst) begin
            first_speaker_differential <= 1'b0;
        end else begin
            first_speaker_differential <= differential_output_select; // [RULE_18]
        end
    end

endmodule // audio_output_routing_control
`default_nettype wire

// >>> sim/route_chk.sv
// assertions on the routing control register ports
`default_nettype none
`include "audio_routing_map.vh"
module route_chk (
    // clock, reset and register port
    input wire logic clock, rst, wr, rd,
    input wire logic [1:0] page,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata, rdata,
    // companion inputs and steering outputs
    input wire logic differential_output_select, loudspeaker_mute,
    input wire logic [5:0] first_path_select, second_path_select, first_path_to_loudspeaker,
    input wire logic [5:0] first_path_to_cell_output, second_path_to_cell_output
);
    timeunit 1ns; timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // a bus cycle aimed at this register
    wire hit = page == 2'h2 && addr == 8'h21;
    AST_RSVD: assert property (rdata[2:0] == 3'h0) else $error("rsvd");
    AST_MISS: assert property (rd && !hit |=> rdata == 16'h0) else $error("miss");
    AST_RBACK: assert property (wr && hit ##1 rd && hit |=>
        rdata == ($past(wdata, 2) & 16'hfff8)) else $error("rback");
    AST_LSK: assert property (wr && hit |-> ##2 first_path_to_loudspeaker ==
        ($past(wdata[15], 2) ? $past(first_path_select) : 6'h0)) else $error("lsk");
    AST_CPO1: assert property (wr && hit |-> ##2 first_path_to_cell_output ==
        ($past(wdata[9], 2) ? $past(first_path_select) & 6'h3e : 6'h0)) else $error("c1");
    AST_CPO2: assert property (wr && hit |-> ##2 second_path_to_cell_output ==
        ($past(wdata[8], 2) && !$past(differential_output_select) ?
        $past(second_path_select) : 6'h0)) else $error("c2");
    AST_MUTE: assert property (wr && hit |-> ##2 loudspeaker_mute == $past(wdata[7], 2))
        else $error("mute");
    AST_RMUTE: assert property ($fell(rst) |-> loudspeaker_mute) else $error("rmute");
endmodule // route_chk
bind audio_output_routing_control route_chk route_chk_i (.*);
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the routing control register
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("Error %0t %h %h", $time, a, b); end end
module tb;
    timeunit 1ns; timeprecision 1ps;
    logic clock = 0, rst = 1, wr = 0, rd = 0, dif = 0, fdif;
    logic [1:0] page = 2'h2;
    logic [7:0] addr = 8'h21;
    logic [15:0] wdata = 16'h0, w, rdata;
    logic [5:0] fsel = 6'h2b, ssel = 6'h15, fl, fc, sc;
    logic [9:0] bits;
    int failures = 0, checks = 0;
    // clock source
    always #5 clock = ~clock;
    audio_output_routing_control audio_output_routing_control_i (.clock, .rst, .page, .addr,
        .wdata, .wr, .rd, .rdata, .differential_output_select(dif), .first_path_select(fsel),
        .second_path_select(ssel), .sidetone_to_loudspeaker(bits[9]),
        .buzzer_to_loudspeaker(bits[8]), .keyclick_to_loudspeaker(bits[7]),
        .cell_input_to_loudspeaker(bits[6]), .microphone_to_cell_output(bits[5]),
        .loudspeaker_mute(bits[4]), .cell_output_mute(bits[3]),
        .loudspeaker_short_protect_off(bits[2]), .virtual_ground_short_protect_off(bits[1]),
        .headset_coupling_select(bits[0]), .first_path_to_loudspeaker(fl),
        .first_path_to_cell_output(fc), .second_path_to_cell_output(sc),
        .first_speaker_differential(fdif));
    // one register cycle: a write when wrt is set, else a read
    task automatic bus(input logic wrt, input logic [1:0] p, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge clock);
        {wr, rd, page, addr, wdata} <= {wrt, !wrt, p, a, d};
        @(posedge clock);
        {wr, rd} <= 2'b00;
        #1;
    endtask
    // read back and compare every output with the word v
    task automatic look(input logic [15:0] v);
        bus(0, 2'h2, 8'h21, 16'h0);
        `CHK(rdata, v & 16'hfff8)
        `CHK(bits[9:5], v[14:10])
        `CHK(bits[4:0], v[7:3])
        `CHK(fl, v[15] ? fsel : 6'h0)
        `CHK(fc, v[9] ? fsel & 6'h3e : 6'h0)
        `CHK(sc, v[8] && !dif ? ssel : 6'h0)
        `CHK(fdif, dif)
    endtask
    // reset word, then each writable bit alone with reserved bits set, then all but bit 8
    task automatic t_fields;
        look(16'h00e0);
        for (int b = 3; b < 17; b++) begin
            // drivers taken as powered down; second-path copy left clear beside bit 15
            w = b == 16 ? 16'hfeff : 16'h0007 | (16'h1 << b);
            bus(1, 2'h2, 8'h21, w);
            look(w);
        end
        $display("fields done");
    endtask
    // writes to another page or offset leave the register alone
    task automatic t_refuse;
        bus(1, 2'h1, 8'h21, 16'h0);
        bus(1, 2'h2, 8'h20, 16'h0);
        look(16'hfeff);
        bus(0, 2'h2, 8'h22, 16'h0);
        `CHK(rdata, 16'h0)
        $display("refuse done");
    endtask
    // write then read with no gap between the strobes
    task automatic t_b2b;
        @(posedge clock);
        {wr, rd, page, addr, wdata} <= {1'b1, 1'b0, 2'h2, 8'h21, 16'h5a5f};
        @(posedge clock);
        {wr, rd} <= 2'b01;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        `CHK(rdata, 16'h5a58)
        $display("b2b done");
    endtask
    // differential mode blocks the second path
    task automatic t_diff;
        @(posedge clock) dif <= 1'b1;
        bus(1, 2'h2, 8'h21, 16'h0100);
        look(16'h0100);
        $display("diff done");
    endtask
    // verdict
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_fields;
        t_refuse;
        t_b2b;
        t_diff;
        report_and_stop;
    end
    // watchdog
    initial begin
        #20000;
        failures++;
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
